// >>> inc/trc_defines.vh
`ifndef TRC_DEFINES_VH
`define TRC_DEFINES_VH

// =====================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define TRC_REG_CTRL 8'h00
`define TRC_REG_OFFSET 8'h04
`define TRC_REG_STEP 8'h08
`define TRC_REG_CYCLE 8'h0C
`define TRC_REG_CALIN 8'h10
`define TRC_REG_STATUS 8'h14
`define TRC_REG_OBJ 8'h18
`define TRC_REG_RAW 8'h1C
`define TRC_REG_CORR 8'h20

// =====================================================================
// Control field positions
`define TRC_CTRL_EN 0
`define TRC_CTRL_TELCAL 1
`define TRC_CTRL_INVMARK 2
`define TRC_CTRL_RDFLAG 3
`define TRC_CTRL_RESTART 4

// Status field positions
`define TRC_ST_CALIB 0
`define TRC_ST_REJECT 1
`define TRC_ST_PEND 2
`define TRC_ST_TXBUSY 3

// =====================================================================
// Reset values
`define TRC_CTRL_RST 4'h0
`define TRC_OFFSET_RST 16'h0000
`define TRC_STEP_RST 8'h00
`define TRC_CYCLE_RST 8'h00

// =====================================================================
// Values and limits, temperatures in 0.01 K
`define TRC_OFS_LIM 20'sd2000
`define TRC_CAL_LIM 21'sd10000
`define TRC_STEP_SCALE 12'd10
`define TRC_INVALID 16'h7FFF
`define TRC_ZERO 16'h0000

// =====================================================================
// Timing
`define TRC_CLK_HZ 32'd50000000
`define TRC_MINUTE_S 32'd60
`define TRC_MINUTE_CYC (`TRC_MINUTE_S * `TRC_CLK_HZ)

`endif

// >>> src/trc_temp_report.v
`timescale 1ns/100ps
`include "trc_defines.vh"

// =====================================================================
// Summary of operation
// - Measure and send only when function enabled
// - Send ambient temperature on one 2-byte object
// - Select factory offset or telegram calibration
// - Factory mode adds offset clamped to 20 K
// - Telegram mode ignores factory offset
// - Accepted calibration maps reading to received value
// - Confirm calibration value, then measure normally
// - Calibration kept in non-volatile storage
// - Uncalibrated telegram mode shows 0 or 7FFF
// - Reject calibration deviating over 100 K
// - New calibration anytime replaces earlier one
// - Send on change by configured step
// - Send periodically every 1 to 255 minutes
// - Only calibrated values reach the object
// - Restart refreshes object and sends if enabled with step or cycle set
// - Post-return send delay never postpones temperature
// - No sends when both disabled, except calibration confirmations; reads need flag
// - Back to factory mode discards telegram calibration
module trc_temp_report
#(
    parameter [31:0] MINUTE_CYC = `TRC_MINUTE_CYC
)
(
    input wire mclk,
    input wire reset,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] sens_temp,
    input wire sens_valid,
    input wire bus_return,
    input wire cfg_download,
    input wire nv_cal_valid,
    input wire [15:0] nv_cal_corr,
    output reg nv_wr,
    output reg nv_wr_valid,
    output reg [15:0] nv_wr_corr,
    output reg tx_req,
    output reg [15:0] tx_data,
    input wire tx_ack,
    output reg [15:0] obj_value,
    input wire rd_req,
    output reg rd_resp,
    output reg [15:0] rd_data
);

// =====================================================================
// Bus float coding: sign-extended mantissa shifted down until it fits
function [15:0] trc_enc;
    input [19:0] v;
    reg [19:0] m;
    reg [3:0] e;
    integer i;
    begin
        m = v;
        e = 4'h0;
        for (i = 0; i < 9; i = i + 1)
        begin
            if ($signed(m) > 2047 || $signed(m) < -2048)
            begin
                m = {m[19], m[19:1]};
                e = e + 4'h1;
            end
        end
        trc_enc = {m[19], e, m[10:0]};
    end
endfunction

// Decoding saturates; huge codes are rejected later by the 100 K window
function [19:0] trc_dec;
    input [15:0] c;
    reg [31:0] m;
    begin
        m = {{21{c[15]}}, c[10:0]};
        m = m << c[14:11];
        if ($signed(m) > 524287)
            trc_dec = 20'h7FFFF;
        else if ($signed(m) < -524288)
            trc_dec = 20'h80000;
        else
            trc_dec = m[19:0];
    end
endfunction

// =====================================================================
// State
reg [3:0] ctrl_r;
reg [15:0] offset_r;
reg [7:0] step_r;
reg [7:0] cycle_r;
reg [15:0] raw_r;
reg [15:0] corr_r;
reg calib_r;
reg reject_r;
reg boot_r;
reg pend_r;
reg [15:0] pend_code_r;
reg [19:0] pend_int_r;
reg [19:0] last_int_r;
reg sent_once_r;
reg [31:0] tick_cnt_r;
reg [7:0] min_cnt_r;
reg tel_mode_d_r;

wire en = ctrl_r[`TRC_CTRL_EN];
wire tel_mode = ctrl_r[`TRC_CTRL_TELCAL];
wire inv_mark = ctrl_r[`TRC_CTRL_INVMARK];
wire rd_flag = ctrl_r[`TRC_CTRL_RDFLAG];

wire apb_wr = psel & penable & pready & pwrite;
wire apb_rd_setup = psel & ~penable & ~pready;
wire cal_wr = apb_wr & (paddr == `TRC_REG_CALIN);
wire restart_wr = apb_wr & (paddr == `TRC_REG_CTRL) &
    pwdata[`TRC_CTRL_RESTART];
wire restart = bus_return | cfg_download | restart_wr;
wire send_on = (step_r != 8'h00) | (cycle_r != 8'h00);

// =====================================================================
// Calibrated value
wire [19:0] raw_ext = {{4{raw_r[15]}}, raw_r};
wire [19:0] ofs_ext = {{4{offset_r[15]}}, offset_r};
wire [19:0] corr_ext = {{4{corr_r[15]}}, corr_r};
reg [19:0] ofs_cl;
reg [19:0] cur_int;
reg cur_ok;
reg [15:0] cur_code;

always @*
begin
    if ($signed(ofs_ext) > $signed(`TRC_OFS_LIM))
        ofs_cl = `TRC_OFS_LIM;
    else if ($signed(ofs_ext) < -$signed(`TRC_OFS_LIM))
        ofs_cl = -`TRC_OFS_LIM;
    else
        ofs_cl = ofs_ext;
    cur_ok = 1'b1;
    if (tel_mode)
    begin
        cur_int = raw_ext + corr_ext;
        cur_ok = calib_r;
    end
    else
        cur_int = raw_ext + ofs_cl;
    if (cur_ok)
        cur_code = trc_enc(cur_int);
    else if (inv_mark)
        cur_code = `TRC_INVALID;
    else
        cur_code = `TRC_ZERO;
end

// =====================================================================
// Calibration telegram check
wire [19:0] rx_int = trc_dec(pwdata[15:0]);
wire [20:0] cal_diff = {rx_int[19], rx_int} - {raw_ext[19], raw_ext};
wire cal_in_win = ($signed(cal_diff) <= $signed(`TRC_CAL_LIM)) &&
    ($signed(cal_diff) >= -$signed(`TRC_CAL_LIM));
wire cal_ok = cal_wr & en & tel_mode & cal_in_win &
    (pwdata[15:0] != `TRC_INVALID);
wire cal_bad = cal_wr & ~cal_ok;

// =====================================================================
// Change and period triggers
wire [20:0] delta = {cur_int[19], cur_int} - (pend_r ?
    {pend_int_r[19], pend_int_r} : {last_int_r[19], last_int_r});
wire [20:0] delta_abs = delta[20] ? (21'd0 - delta) : delta;
wire [11:0] step_int = {4'h0, step_r} * `TRC_STEP_SCALE;
wire change_hit = en & cur_ok & (step_r != 8'h00) &
    (~(sent_once_r | pend_r) | (delta_abs >= {9'h000, step_int}));
wire tick = (tick_cnt_r >= MINUTE_CYC - 32'd1);
wire cyc_hit = en & (cycle_r != 8'h00) & tick &
    (min_cnt_r >= cycle_r - 8'd1);
// Uncalibrated periodic sends only carry the invalid marker, never 0
wire cyc_send = cyc_hit & (cur_ok | inv_mark);
// No start-up delay applies: restart sends immediately
wire rst_send = restart & en & send_on &
    (cur_ok | inv_mark);

// =====================================================================
// Configuration registers
always @(posedge mclk)
begin
    if (reset)
    begin
        ctrl_r <= `TRC_CTRL_RST;
        offset_r <= `TRC_OFFSET_RST;
        step_r <= `TRC_STEP_RST;
        cycle_r <= `TRC_CYCLE_RST;
    end
    else if (apb_wr)
    begin
        case (paddr)
            `TRC_REG_CTRL: ctrl_r <= pwdata[3:0];
            `TRC_REG_OFFSET: offset_r <= pwdata[15:0];
            `TRC_REG_STEP: step_r <= pwdata[7:0];
            `TRC_REG_CYCLE: cycle_r <= pwdata[7:0];
            default: ;
        endcase
    end
end

// =====================================================================
// Sensor sample and calibration store
always @(posedge mclk)
begin
    if (reset)
    begin
        raw_r <= 16'h0000;
        corr_r <= 16'h0000;
        calib_r <= 1'b0;
        boot_r <= 1'b1;
        tel_mode_d_r <= 1'b0;
        reject_r <= 1'b0;
        nv_wr <= 1'b0;
        nv_wr_valid <= 1'b0;
        nv_wr_corr <= 16'h0000;
    end
    else
    begin
        tel_mode_d_r <= tel_mode;
        nv_wr <= 1'b0;
        if (sens_valid)
            raw_r <= sens_temp;
        if (boot_r)
        begin
            // Stored calibration is picked up once after reset release
            boot_r <= 1'b0;
            corr_r <= nv_cal_corr;
            calib_r <= nv_cal_valid;
        end
        else if (cal_ok)
        begin
            corr_r <= cal_diff[15:0];
            calib_r <= 1'b1;
            nv_wr <= 1'b1;
            nv_wr_valid <= 1'b1;
            nv_wr_corr <= cal_diff[15:0];
        end
        else if (tel_mode_d_r & ~tel_mode)
        begin
            corr_r <= 16'h0000;
            calib_r <= 1'b0;
            nv_wr <= 1'b1;
            nv_wr_valid <= 1'b0;
            nv_wr_corr <= 16'h0000;
        end
        // A rejection arriving with the clearing write still sticks
        if (cal_bad)
            reject_r <= 1'b1;
        else if (apb_wr && paddr == `TRC_REG_STATUS &&
            pwdata[`TRC_ST_REJECT])
            reject_r <= 1'b0;
    end
end

// =====================================================================
// Periodic timer
always @(posedge mclk)
begin
    if (reset || restart || !en || cycle_r == 8'h00 ||
        (apb_wr && paddr == `TRC_REG_CYCLE))
    begin
        tick_cnt_r <= 32'h00000000;
        min_cnt_r <= 8'h00;
    end
    else if (tick)
    begin
        tick_cnt_r <= 32'h00000000;
        if (cyc_hit)
            min_cnt_r <= 8'h00;
        else
            min_cnt_r <= min_cnt_r + 8'd1;
    end
    else
        tick_cnt_r <= tick_cnt_r + 32'd1;
end

// =====================================================================
// Object value, send queue and telegram handshake
always @(posedge mclk)
begin
    if (reset)
    begin
        obj_value <= `TRC_ZERO;
        pend_r <= 1'b0;
        pend_code_r <= 16'h0000;
        pend_int_r <= 20'h00000;
        last_int_r <= 20'h00000;
        sent_once_r <= 1'b0;
        tx_req <= 1'b0;
        tx_data <= 16'h0000;
    end
    else
    begin
        if (!en)
            obj_value <= `TRC_ZERO;
        else if (cal_ok)
            obj_value <= pwdata[15:0];
        else
            obj_value <= cur_code;
        if (!en)
            pend_r <= 1'b0;
        else if (cal_ok)
        begin
            // Confirmation carries the received value itself
            pend_r <= 1'b1;
            pend_code_r <= pwdata[15:0];
            pend_int_r <= rx_int;
        end
        else if (change_hit || cyc_send || rst_send)
        begin
            pend_r <= 1'b1;
            pend_code_r <= cur_code;
            pend_int_r <= cur_int;
        end
        else if (pend_r && !tx_req)
            pend_r <= 1'b0;
        if (tx_req)
        begin
            if (tx_ack)
                tx_req <= 1'b0;
        end
        else if (pend_r && en)
        begin
            tx_req <= 1'b1;
            tx_data <= pend_code_r;
            last_int_r <= pend_int_r;
            sent_once_r <= 1'b1;
        end
        // Reference restarts so the first valid value goes out
        if (restart || (tel_mode_d_r != tel_mode))
            sent_once_r <= 1'b0;
    end
end

// =====================================================================
// Remote read requests
always @(posedge mclk)
begin
    if (reset)
    begin
        rd_resp <= 1'b0;
        rd_data <= 16'h0000;
    end
    else
    begin
        rd_resp <= rd_req & rd_flag & en;
        if (rd_req && rd_flag && en)
            rd_data <= obj_value;
    end
end

// =====================================================================
// APB slave, one wait-free access after the setup cycle
always @(posedge mclk)
begin
    if (reset)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        pready <= apb_rd_setup;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        if (apb_rd_setup)
        begin
            case (paddr)
                `TRC_REG_CTRL: prdata <= {28'h0000000, ctrl_r};
                `TRC_REG_OFFSET: prdata <= {16'h0000, offset_r};
                `TRC_REG_STEP: prdata <= {24'h000000, step_r};
                `TRC_REG_CYCLE: prdata <= {24'h000000, cycle_r};
                `TRC_REG_CALIN: prdata <= 32'h00000000;
                `TRC_REG_STATUS: prdata <= {28'h0000000, tx_req,
                    pend_r, reject_r, calib_r};
                `TRC_REG_OBJ: prdata <= {16'h0000, obj_value};
                `TRC_REG_RAW: prdata <= {16'h0000, raw_r};
                `TRC_REG_CORR: prdata <= {16'h0000, corr_r};
                default: pslverr <= 1'b1;
            endcase
        end
    end
end

endmodule

// >>> tb/trc_temp_report_properties.sv
`timescale 1ns/100ps
`include "trc_defines.vh"

// ==========
// Checker on the top ports; control fields shadowed from APB writes
module trc_temp_checker
(
    input wire mclk,
    input wire reset,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire pready,
    input wire tx_req,
    input wire [15:0] tx_data,
    input wire tx_ack,
    input wire [15:0] obj_value,
    input wire rd_req,
    input wire rd_resp,
    input wire [15:0] rd_data,
    input wire nv_wr,
    input wire nv_wr_valid
);
    reg [3:0] ctl_r;
    reg [7:0] step_r;
    reg [7:0] cyc_r;
    reg cal_r;
    reg [3:0] qt_r;
    wire wr_ok = psel && penable && pready && pwrite;
    wire ctl_wr = wr_ok && paddr == `TRC_REG_CTRL;
    wire cal_wr = wr_ok && paddr == `TRC_REG_CALIN;
    // Calibration counts from the edge its store pulse shows
    wire cal_ok = cal_r || (nv_wr && nv_wr_valid);
    wire quiet = !ctl_r[0] || (step_r == 8'h00 && cyc_r == 8'h00);

    always @(posedge mclk)
    begin
        if (reset)
        begin
            ctl_r <= 4'h0;
            step_r <= 8'h00;
            cyc_r <= 8'h00;
            cal_r <= 1'b0;
            qt_r <= 4'h0;
        end
        else
        begin
            if (ctl_wr)
                ctl_r <= pwdata[3:0];
            if (wr_ok && paddr == `TRC_REG_STEP)
                step_r <= pwdata[7:0];
            if (wr_ok && paddr == `TRC_REG_CYCLE)
                cyc_r <= pwdata[7:0];
            if (nv_wr)
                cal_r <= nv_wr_valid;
            // A confirmation may still be in flight after a calibration
            if (cal_wr || !quiet)
                qt_r <= 4'h0;
            else if (qt_r != 4'hF)
                qt_r <= qt_r + 4'h1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence

    apb_answer_a: assert property (setup_s |=> answer_s)
        else $error("apb answer missing or too long");
    tx_hold_a: assert property (
        tx_req && !tx_ack |=> tx_req && $stable(tx_data))
        else $error("telegram request changed before ack");
    tx_drop_a: assert property (tx_req && tx_ack |=> !tx_req)
        else $error("telegram request held after ack");
    read_answer_a: assert property (
        rd_req && ctl_r[3] && ctl_r[0] |=>
        rd_resp && rd_data == $past(obj_value))
        else $error("remote read not answered");
    read_gate_a: assert property (
        rd_resp |-> $past(rd_req) && $past(ctl_r[3]))
        else $error("remote read answered without flag");
    disabled_obj_a: assert property (
        !ctl_r[0] [*4] |-> obj_value == 16'h0000)
        else $error("object not cleared while disabled");
    uncal_mark_a: assert property (
        (ctl_r[2:0] == 3'b111 && !cal_ok) [*4] |-> obj_value == `TRC_INVALID)
        else $error("invalid marker missing");
    uncal_zero_a: assert property (
        (ctl_r[2:0] == 3'b011 && !cal_ok) [*4] |-> obj_value == 16'h0000)
        else $error("uncalibrated object not zero");
    factory_discard_a: assert property (
        ctl_wr && ctl_r[1] && !pwdata[1] |-> ##[1:2] (nv_wr && !nv_wr_valid))
        else $error("calibration not discarded");
    nv_cause_a: assert property (
        nv_wr |-> $past(cal_wr) || $past(cal_wr, 2) ||
        $past(ctl_wr) || $past(ctl_wr, 2))
        else $error("store without cause");
    quiet_tx_a: assert property (qt_r == 4'hF |-> !tx_req)
        else $error("telegram sent while sending is off");
endmodule

bind trc_temp_report trc_temp_checker i_chk (.mclk, .reset, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pready, .tx_req, .tx_data, .tx_ack,
    .obj_value, .rd_req, .rd_resp, .rd_data, .nv_wr, .nv_wr_valid);

// >>> tb/trc_link_model.sv
`timescale 1ns/100ps

// ==========
// Far-side subscriber: acks each telegram, alternately prompt and slow
module trc_link_model
(
    input wire mclk,
    input wire reset,
    input wire tx_req,
    input wire [15:0] tx_data,
    output reg tx_ack = 1'b0,
    output reg rd_req = 1'b0,
    input wire rd_resp,
    input wire [15:0] rd_data
);
    integer sent = 0;
    reg [15:0] last = 16'h0000;
    reg hold = 1'b0;
    reg [2:0] w = 3'h0;
    reg [2:0] dly = 3'h0;

    // One idle cycle after each ack so a request that is still high
    // during its drop edge is not taken twice
    always @(posedge mclk)
    begin
        if (reset)
        begin
            tx_ack <= 1'b0;
            hold <= 1'b0;
            w <= 3'h0;
        end
        else if (tx_ack || hold)
        begin
            tx_ack <= 1'b0;
            hold <= tx_ack;
        end
        else if (tx_req && w == dly)
        begin
            tx_ack <= 1'b1;
            sent <= sent + 1;
            last <= tx_data;
            w <= 3'h0;
            dly <= dly ^ 3'h3;
        end
        else if (tx_req)
            w <= w + 3'h1;
    end

    task remote_read(output ok, output [15:0] d);
        @(posedge mclk);
        rd_req <= 1'b1;
        @(posedge mclk);
        rd_req <= 1'b0;
        @(posedge mclk);
        ok = rd_resp;
        d = rd_data;
    endtask
endmodule

// >>> tb/trc_temp_report_bench.sv
`timescale 1ns/100ps
`include "trc_defines.vh"

// ==========
// Bench top
module trc_temp_report_bench;
    reg mclk;
    reg reset;
    reg [7:0] paddr;
    reg psel;
    reg penable;
    reg pwrite;
    reg [31:0] pwdata;
    reg [15:0] sens_temp;
    reg sens_valid;
    reg bus_return;
    reg cfg_download;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire tx_req;
    wire [15:0] tx_data;
    wire tx_ack;
    wire [15:0] obj_value;
    wire rd_req;
    wire rd_resp;
    wire [15:0] rd_data;
    reg perr;
    reg ok;
    reg [31:0] q;
    reg [15:0] d;
    integer err_count;
    integer checks;
    integer base;
    integer i;

    trc_temp_report #(.MINUTE_CYC(32'd20)) i_dut (.mclk(mclk), .reset(reset),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sens_temp(sens_temp), .sens_valid(sens_valid),
        .bus_return(bus_return), .cfg_download(cfg_download),
        .nv_cal_valid(1'b0), .nv_cal_corr(16'h0000), .nv_wr(),
        .nv_wr_valid(), .nv_wr_corr(), .tx_req(tx_req), .tx_data(tx_data),
        .tx_ack(tx_ack), .obj_value(obj_value), .rd_req(rd_req),
        .rd_resp(rd_resp), .rd_data(rd_data));

    trc_link_model i_link (.mclk(mclk), .reset(reset), .tx_req(tx_req),
        .tx_data(tx_data), .tx_ack(tx_ack), .rd_req(rd_req),
        .rd_resp(rd_resp), .rd_data(rd_data));

    // ==========
    // Tasks
    task chk(input [32:0] s, input [32:0] e, input string n);
        checks = checks + 1;
        if (s !== e)
        begin
            err_count = err_count + 1;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task end_sim;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Bus float, exact values only: mantissa halved until it fits
    function [15:0] enc(input integer v);
        integer e;
        e = 0;
        while (v > 2047 || v < -2048)
        begin
            v = v >>> 1;
            e = e + 1;
        end
        enc = {v[31], e[3:0], v[10:0]};
    endfunction

    // Request held until pready is seen at an edge; data taken there
    task apb(input w, input [7:0] a, input [31:0] v);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task sense(input [15:0] v);
        @(posedge mclk);
        sens_temp <= v;
        sens_valid <= 1'b1;
        @(posedge mclk);
        sens_valid <= 1'b0;
    endtask

    task pulse(input s);
        @(posedge mclk);
        bus_return <= s;
        cfg_download <= !s;
        @(posedge mclk);
        bus_return <= 1'b0;
        cfg_download <= 1'b0;
    endtask

    task obj_is(input [15:0] e);
        integer n;
        for (n = 0; n < 30 && obj_value !== e; n = n + 1)
        begin
            @(posedge mclk);
            #1;
        end
        chk(obj_value, e, "object");
    endtask

    task settle;
        repeat (20) @(posedge mclk);
        base = i_link.sent;
    endtask

    // Absence of a send can only be judged over a fixed span
    task sends(input integer k, input [15:0] e);
        repeat (40) @(posedge mclk);
        chk(i_link.sent - base, k, "send count");
        if (k > 0)
            chk(i_link.last, e, "sent value");
        base = i_link.sent;
    endtask

    // ==========
    // Clock, watchdog, tests
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count = err_count + 1;
        end_sim;
    end

    initial
    begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {sens_temp, sens_valid, bus_return, cfg_download} = 19'h0;
        err_count = 0;
        checks = 0;
        base = 0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        for (i = 0; i <= 32; i = i + 4)
        begin
            apb(1'b0, i[7:0], 32'h0);
            chk({perr, q}, 33'h0, "reset read");
        end
        apb(1'b1, 8'h24, 32'h5A);
        apb(1'b0, 8'h24, 32'h0);
        chk({perr, q}, {1'b1, 32'h0}, "unmapped");
        $display("test registers done");
        apb(1'b1, `TRC_REG_STEP, 32'h1);
        sense(16'd1000);
        sends(0, 16'h0);
        i_link.remote_read(ok, d);
        chk({ok, obj_value}, 17'h0, "disabled");
        $display("test disabled done");
        apb(1'b1, `TRC_REG_OFFSET, 32'd3000);
        apb(1'b0, `TRC_REG_OFFSET, 32'h0);
        chk(q, 32'd3000, "offset");
        apb(1'b1, `TRC_REG_CTRL, 32'h9);
        sense(16'd1000);
        obj_is(enc(3000));
        sends(1, enc(3000));
        apb(1'b1, `TRC_REG_OFFSET, 32'hFFFFF63C);
        sense(16'd1000);
        obj_is(enc(-1000));
        sends(1, enc(-1000));
        sense(16'd1005);
        sends(0, 16'h0);
        sense(16'd1010);
        sends(1, enc(-990));
        for (i = 0; i < 2; i = i + 1)
        begin
            pulse(i[0]);
            sends(1, enc(-990));
        end
        apb(1'b1, `TRC_REG_STEP, 32'h0);
        apb(1'b1, `TRC_REG_CYCLE, 32'h1);
        settle;
        repeat (200) @(posedge mclk);
        chk(i_link.sent - base inside {[9:11]}, 1'b1, "cyclic");
        chk(i_link.last, enc(-990), "cyclic value");
        apb(1'b1, `TRC_REG_CYCLE, 32'h0);
        settle;
        sense(16'd1500);
        obj_is(enc(-500));
        pulse(1'b1);
        sends(0, 16'h0);
        i_link.remote_read(ok, d);
        chk({ok, d}, {1'b1, enc(-500)}, "read");
        apb(1'b1, `TRC_REG_CTRL, 32'h1);
        i_link.remote_read(ok, d);
        chk(ok, 1'b0, "read flag");
        $display("test factory done");
        apb(1'b1, `TRC_REG_STEP, 32'h1);
        apb(1'b1, `TRC_REG_CTRL, 32'h3);
        sense(16'd1000);
        obj_is(16'h0000);
        apb(1'b1, `TRC_REG_CTRL, 32'h7);
        obj_is(`TRC_INVALID);
        apb(1'b1, `TRC_REG_CALIN, enc(12000));
        settle;
        obj_is(`TRC_INVALID);
        apb(1'b0, `TRC_REG_STATUS, 32'h0);
        chk(q & 32'h3, 32'h2, "status");
        apb(1'b1, `TRC_REG_CALIN, enc(11000));
        obj_is(enc(11000));
        sends(1, enc(11000));
        sense(16'd1200);
        obj_is(enc(11200));
        sends(1, enc(11200));
        apb(1'b1, `TRC_REG_CALIN, enc(2000));
        sense(16'd1300);
        obj_is(enc(2100));
        apb(1'b1, `TRC_REG_CTRL, 32'h1);
        obj_is(enc(-700));
        apb(1'b1, `TRC_REG_CTRL, 32'h3);
        obj_is(16'h0000);
        $display("test telegram done");
        end_sim;
    end
endmodule
